//--- bench/motor_option_register_bank_monitor.sv
// checker: decoded option settings and axi4-lite answers of the option register bank
// assumes it is bound into the bank and sees only the bank's ports
module motor_option_register_bank_monitor (
    input logic        aclk, aresetn,                                     // clock, sync reset
    input logic [7:0]  s_axi_awaddr, s_axi_araddr,                        // addresses
    input logic [31:0] s_axi_wdata, s_axi_rdata,                          // data
    input logic [3:0]  s_axi_wstrb,                                       // write strobes
    input logic [1:0]  s_axi_bresp, s_axi_rresp,                          // responses
    input logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, // write handshakes
    input logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, // answers
    input logic        no_motor_fault_enable, torque_fault_enable, speed_fault_enable, lock_limit_fault_enable,
    input logic        inductive_surge_guard_enable, mechanical_surge_guard_enable, surge_clamp_to_24v,
    input logic        release_high_impedance, accel_limit_active, closed_loop_stuck_enable, position_detect_bypass,
    input logic        open_loop_stuck_enable, regulator_3v3, speed_input_pwm, closed_loop_allowed,
    input logic        tach_first_open_loop_only,                         // tach mode
    input logic [9:0]  dead_time_ns,                                      // dead time
    input logic [11:0] accel_current_limit_ma, lock_current_limit_ma      // current limits
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // a store is checked only when both halves are taken on one edge with lane 0 on
    logic       wr_go;
    logic [7:0] wd1_q, wd2_q;
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    // written byte delayed to the edge where decoded outputs must show it
    always @(posedge aclk) begin
        wd1_q <= s_axi_wdata[7:0];
        wd2_q <= wd1_q;
    end
    sequence wr_at(logic [7:0] a);
        wr_go && s_axi_awaddr == a;
    endsequence
    chk_fault_bits: assert property (wr_at(8'h9c) |=> ##1
        {no_motor_fault_enable, torque_fault_enable, speed_fault_enable, lock_limit_fault_enable,
        inductive_surge_guard_enable, mechanical_surge_guard_enable, surge_clamp_to_24v, release_high_impedance} == wd2_q)
        else $error("fault option outputs differ from stored byte");
    chk_accel_limit: assert property (wr_at(8'ha0) |=> ##1
        accel_limit_active == (wd2_q[7:4] != 4'h0) && accel_current_limit_ma == wd2_q[7:4] * 200)
        else $error("acceleration limit decode wrong");
    chk_lock_limit: assert property (wr_at(8'ha0) |=> ##1 lock_current_limit_ma == (wd2_q[3:1] + 1) * 400)
        else $error("lock limit decode wrong");
    chk_dead_time: assert property (wr_at(8'ha4) |=> ##1
        dead_time_ns == (wd2_q[3:0] + 1) * 40 && closed_loop_stuck_enable == wd2_q[7])
        else $error("dead time decode wrong");
    chk_sense_decode: assert property (wr_at(8'ha8) |=> ##1
        position_detect_bypass == (wd2_q[7:4] == 4'h0) && open_loop_stuck_enable == wd2_q[3] && regulator_3v3 == wd2_q[2])
        else $error("sense option decode wrong");
    chk_tach_decode: assert property (wr_at(8'hac) |=> ##1
        speed_input_pwm == wd2_q[1] && closed_loop_allowed == !wd2_q[0] && tach_first_open_loop_only == (wd2_q[7:6] == 2'b10))
        else $error("tach option decode wrong");
    chk_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response missing");
    chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_read_upper: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
        else $error("read answer late or upper bits set");
    chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00 |=>
        s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    cover property (wr_at(8'h9c));
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
    cover property (s_axi_rvalid && s_axi_rresp == 2'b00);
endmodule // motor_option_register_bank_monitor

//--- bench/motor_option_register_bank_tb.sv
// self-checking bench for the option register bank, driven over axi4-lite
// assumes the bank and its monitor are compiled before this file
module motor_option_register_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, no_motor_fault_enable, torque_fault_enable;
    logic speed_fault_enable, lock_limit_fault_enable, inductive_surge_guard_enable, mechanical_surge_guard_enable;
    logic surge_clamp_to_24v, release_high_impedance, accel_limit_active, closed_loop_stuck_enable, regulator_3v3;
    logic position_detect_bypass, open_loop_stuck_enable, tach_in_open_loop, tach_first_open_loop_only;
    logic speed_input_pwm, closed_loop_allowed;
    logic [1:0]  s_axi_bresp, s_axi_rresp, tach_pulses, tach_cycles, kt_high_x2, kt_low_x4;
    logic [2:0]  closed_loop_accel, alignment_duration;
    logic [3:0]  s_axi_wstrb;
    logic [4:0]  loop_handover_speed, dead_time_cycles;
    logic [6:0]  position_sense_rate_hz;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [9:0]  dead_time_ns, alignment_time_cs;
    logic [11:0] position_sense_threshold_ma, handover_speed_dhz, accel_current_limit_ma, lock_current_limit_ma;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    int          err_total, checks_done;
    wire  [7:0]  fault_bits = {no_motor_fault_enable, torque_fault_enable, speed_fault_enable, lock_limit_fault_enable,
        inductive_surge_guard_enable, mechanical_surge_guard_enable, surge_clamp_to_24v, release_high_impedance};

    motor_option_register_bank motor_option_register_bank_inst (.*);

    // 50 ns clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("%0d mismatches in %0d checks", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // bounded waits: running out ends the run as a mismatch
    task automatic tick(inout int n);
        n++;
        if (n > 40) begin
            err_total++;
            $display("timeout at %0t", $time);
            print_verdict();
        end
    endtask
    task automatic wait_hi(ref logic s);
        int n = 0;
        @(negedge aclk);
        while (s !== 1'b1) begin
            tick(n);
            @(negedge aclk);
        end
    endtask
    // readies are looked at mid-cycle, so what is seen is what the next edge samples
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
        logic pa = 1'b1, pw = 1'b1, ta, tw;
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= st;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {2'b11, st != 4'h0};
        while (pa || pw) begin
            @(negedge aclk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            {pa, pw} = {pa && !ta, pw && !tw};
            tick(n);
        end
        wait_hi(s_axi_bvalid);
        cmp(s_axi_bresp, er);
        // empty-strobe writes take the answer a cycle late, so it must stand
        if (!s_axi_bready) begin
            @(posedge aclk);
            s_axi_bready <= 1'b1;
        end
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        wait_hi(s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        wait_hi(s_axi_rvalid);
        cmp(s_axi_rdata, ed);
        cmp(s_axi_rresp, er);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // byte addresses are four times the register index
    task automatic t_reset();
        logic [7:0] ra [6] = '{8'h98, 8'h9c, 8'ha0, 8'ha4, 8'ha8, 8'hac};
        foreach (ra[i]) rd(ra[i], 32'h0, 2'b00);
        cmp({lock_current_limit_ma, dead_time_ns, position_detect_bypass, position_sense_rate_hz},
            {12'd400, 10'd40, 1'b1, 7'd12});
        cmp({closed_loop_allowed, alignment_time_cs, fault_bits}, {1'b1, 10'd530, 8'h00});
        $display("reset values done");
    endtask
    // walking one through every fault option bit, then all clear
    task automatic t_fault();
        for (int i = 0; i < 9; i++) begin
            wr(8'h9c, 8'h01 << i, 4'h1, 2'b00);
            rd(8'h9c, 32'h1 << i & 32'hff, 2'b00);
            cmp(fault_bits, 32'h1 << i & 32'hff);
        end
        $display("fault options done");
    endtask
    task automatic t_limits();
        logic [7:0] v [4] = '{8'h00, 8'h13, 8'h5e, 8'hf1};
        foreach (v[i]) begin
            wr(8'ha0, v[i], 4'hf, 2'b00);
            rd(8'ha0, v[i] & 8'hfe, 2'b00);
            cmp({accel_limit_active, accel_current_limit_ma}, {v[i][7:4] != 4'h0, 12'(v[i][7:4] * 200)});
            cmp(lock_current_limit_ma, (v[i][3:1] + 1) * 400);
            wr(8'ha4, v[i] ^ 8'h88, 4'h1, 2'b00);
            cmp(dead_time_ns, ((v[i][3:0] ^ 4'h8) + 1) * 40);
            cmp(dead_time_cycles, (((v[i][3:0] ^ 4'h8) + 1) * 40 + 49) / 50);
            cmp({closed_loop_stuck_enable, closed_loop_accel}, v[i][7:4] ^ 4'h8);
        end
        $display("limits and dead time done");
    endtask
    task automatic t_sense();
        logic [7:0] v [4] = '{8'h00, 8'h1d, 8'h86, 8'hf7};
        int hz [4] = '{12, 24, 47, 95};
        foreach (v[i]) begin
            wr(8'ha8, v[i], 4'h1, 2'b00);
            cmp(position_detect_bypass, v[i][7:4] == 4'h0);
            cmp(position_sense_threshold_ma, v[i][7:4] == 4'h0 ? 0 : (v[i][7:4] + 1) * 200);
            cmp(position_sense_rate_hz, hz[i]);
            cmp({open_loop_stuck_enable, regulator_3v3}, v[i][3:2]);
        end
        $display("sense options done");
    endtask
    // code i placed in every two-bit field at once
    task automatic t_tach();
        logic [3:0] ratio [4] = '{4'h5, 4'hb, 4'h6, 4'h7};
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            d = 8'h55 * i;
            wr(8'hac, d, 4'h1, 2'b00);
            cmp({tach_in_open_loop, tach_first_open_loop_only}, {i == 0 || i == 2, i == 2});
            cmp({tach_pulses, tach_cycles}, ratio[i]);
            cmp({kt_high_x2, kt_low_x4}, {i[0] ? 2'd0 : 2'd3, i[1] ? 2'd2 : 2'd3});
            cmp({speed_input_pwm, closed_loop_allowed}, {d[1], !d[0]});
        end
        $display("tach options done");
    endtask
    task automatic t_speed_align();
        logic [4:0] v [5] = '{5'h00, 5'h01, 5'h0f, 5'h10, 5'h1f};
        int cs [8] = '{530, 270, 130, 67, 33, 16, 8, 4};
        foreach (v[i]) begin
            loop_handover_speed <= v[i];
            repeat (3) @(posedge aclk);
            cmp(handover_speed_dhz, v[i][4] ? (v[i][3:0] + 1) * 128 : v[i] * 8);
        end
        for (int c = 0; c < 8; c++) begin
            wr(8'h98, 8'hf8 | c, 4'h1, 2'b00);
            rd(8'h98, c, 2'b00);
            cmp({alignment_duration, alignment_time_cs}, {c[2:0], 10'(cs[c])});
        end
        $display("handover speed and align done");
    endtask
    // refusals, a dropped lane, then a reset in mid-run
    task automatic t_errors();
        wr(8'h9c, 8'h3c, 4'h1, 2'b00);
        wr(8'h9c, 8'hc3, 4'h0, 2'b00);
        wr(8'h00, 8'hff, 4'hf, 2'b10);
        wr(8'h9e, 8'hff, 4'hf, 2'b10);
        rd(8'h00, 32'h0, 2'b10);
        rd(8'h9c, 32'h3c, 2'b00);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h9c, 32'h0, 2'b00);
        cmp(fault_bits, 8'h00);
        $display("refusals and reset done");
    endtask

    // reset for 12 cycles, then each scenario in turn
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata, loop_handover_speed} = '0;
        {err_total, checks_done} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_fault();
        t_limits();
        t_sense();
        t_tach();
        t_speed_align();
        t_errors();
        print_verdict();
    end
endmodule // motor_option_register_bank_tb

bind motor_option_register_bank motor_option_register_bank_monitor motor_option_register_bank_monitor_inst (.*);

//--- rtl/motor_opt_consts.vh
// offsets, field positions and decode constants of the option register bank
// assumes inclusion by bare name from the bank module
`ifndef MOTOR_OPT_CONSTS_VH
`define MOTOR_OPT_CONSTS_VH
// printed offsets are register indices; byte address is four times the index
`define IDX_ALIGN        6'h26
`define IDX_FAULT        6'h27
`define IDX_CURLIM       6'h28
`define IDX_CLDT         6'h29
`define IDX_IPDREG       6'h2a
`define IDX_TACH         6'h2b
`define ADDR_W           8
`define RST_OPT          8'h00
`define RST_ALIGN        8'h00
`define ALIGN_MASK       8'h07
`define CURLIM_MASK      8'hfe
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
// per-step units: 0.2 A = 200 mA, 0.4 A = 400 mA, 40 ns, 0.8 Hz = 8 dHz
`define ACCEL_STEP_MA    10'd200
`define LOCK_STEP_MA     10'd400
`define IPD_STEP_MA      10'd200
`define DEAD_STEP_NS     10'd40
`define CLK_PERIOD_NS    10'd50
`define SPD_STEP0_DHZ    12'd8
`define SPD_STEP1_DHZ    12'd128
`endif

//--- rtl/motor_option_register_bank.v
// option register bank of a sensorless three-phase motor controller
// assumes an axi4-lite master on aclk; decoded settings drive the motor core
module motor_option_register_bank (
    input  wire        aclk,                        // 20 MHz clock
    input  wire        aresetn,                     // sync reset, active low
    input  wire [7:0]  s_axi_awaddr,                // write address
    input  wire        s_axi_awvalid,               // write address valid
    output wire        s_axi_awready,               // write address ready
    input  wire [31:0] s_axi_wdata,                 // write data
    input  wire [3:0]  s_axi_wstrb,                 // write strobes
    input  wire        s_axi_wvalid,                // write data valid
    output wire        s_axi_wready,                // write data ready
    output reg  [1:0]  s_axi_bresp,                 // write response
    output reg         s_axi_bvalid,                // write response valid
    input  wire        s_axi_bready,                // write response ready
    input  wire [7:0]  s_axi_araddr,                // read address
    input  wire        s_axi_arvalid,               // read address valid
    output wire        s_axi_arready,               // read address ready
    output reg  [31:0] s_axi_rdata,                 // read data
    output reg  [1:0]  s_axi_rresp,                 // read response
    output reg         s_axi_rvalid,                // read valid
    input  wire        s_axi_rready,                // read ready
    input  wire [4:0]  loop_handover_speed,         // handover code from previous bank
    output reg         no_motor_fault_enable,       // no motor fault detect on
    output reg         torque_fault_enable,         // abnormal torque constant detect on
    output reg         speed_fault_enable,          // abnormal speed detect on
    output reg         lock_limit_fault_enable,     // lock current limit detect on
    output reg         inductive_surge_guard_enable, // inductive anti-surge on
    output reg         mechanical_surge_guard_enable, // mechanical anti-surge on
    output reg         surge_clamp_to_24v,          // 1 clamp to 24 V, 0 to supply
    output reg         release_high_impedance,      // 1 hi-z, 0 brake on release
    output reg         accel_limit_active,          // acceleration limit applied
    output reg  [11:0] accel_current_limit_ma,      // acceleration limit, mA
    output reg  [11:0] lock_current_limit_ma,       // lock limit, mA
    output reg         closed_loop_stuck_enable,    // closed-loop stuck detect on
    output reg  [2:0]  closed_loop_accel,           // closed-loop accel code
    output reg  [9:0]  dead_time_ns,                // gate dead time, ns
    output reg  [4:0]  dead_time_cycles,            // dead time in aclk cycles, rounded up
    output reg         position_detect_bypass,      // align and go, no ipd
    output reg  [11:0] position_sense_threshold_ma, // ipd current threshold, mA
    output reg  [6:0]  position_sense_rate_hz,      // ipd pulse rate, Hz
    output reg         open_loop_stuck_enable,      // open-loop stuck detect on
    output reg         regulator_3v3,               // 1 3.3 V, 0 5 V
    output reg         tach_in_open_loop,           // tach pulses in open loop
    output reg         tach_first_open_loop_only,   // tach only in first open loop
    output reg  [1:0]  tach_pulses,                 // pulses per cycle group
    output reg  [1:0]  tach_cycles,                 // electrical cycles per group
    output reg  [1:0]  kt_high_x2,                  // upper bound, Kt*x/2: 3 or 4
    output reg  [1:0]  kt_low_x4,                   // lower bound, Kt*x/4: 3 or 2
    output reg         speed_input_pwm,             // 1 pwm, 0 analog
    output reg         closed_loop_allowed,         // handover to closed loop permitted
    output reg  [11:0] handover_speed_dhz,          // handover speed, 0.1 Hz units
    output reg  [9:0]  alignment_time_cs,           // align time, 0.01 s units
    output reg  [2:0]  alignment_duration           // align code
);
`include "motor_opt_consts.vh"

    reg  [7:0] align_q, fault_q, curlim_q, cldt_q, ipdreg_q, tach_q;
    reg        aw_held_q, w_held_q;
    reg  [7:0] awaddr_q;
    reg  [7:0] wdata_q;
    reg        wstb_q;

    // word index from byte address; misaligned addresses are unmapped
    function [6:0] reg_index;
        input [7:0] a;
        begin
            reg_index = (a[1:0] == 2'b00) ? {1'b0, a[7:2]} : 7'h7f;
        end
    endfunction

    // read mux, shared between read path and hit check
    function [8:0] read_reg;
        input [6:0] idx;
        input [7:0] r0, r1, r2, r3, r4, r5;
        begin
            case (idx)
                {1'b0, `IDX_ALIGN}:  read_reg = {1'b1, r0};
                {1'b0, `IDX_FAULT}:  read_reg = {1'b1, r1};
                {1'b0, `IDX_CURLIM}: read_reg = {1'b1, r2};
                {1'b0, `IDX_CLDT}:   read_reg = {1'b1, r3};
                {1'b0, `IDX_IPDREG}: read_reg = {1'b1, r4};
                {1'b0, `IDX_TACH}:   read_reg = {1'b1, r5};
                default:             read_reg = 9'h000;
            endcase
        end
    endfunction

    // address and data are each accepted once, in either order
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire       aw_now  = aw_held_q || (s_axi_awvalid && s_axi_awready);
    wire       w_now   = w_held_q || (s_axi_wvalid && s_axi_wready);
    wire [7:0] wa      = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [7:0] wd      = w_held_q ? wdata_q : s_axi_wdata[7:0];
    wire       wst     = w_held_q ? wstb_q : s_axi_wstrb[0];
    wire       do_wr   = aw_now && w_now;
    wire [6:0] widx    = reg_index(wa);
    wire [8:0] wsel    = read_reg(widx, align_q, fault_q, curlim_q, cldt_q, ipdreg_q, tach_q);
    wire       whit    = wsel[8];

    // write channel capture and response; only lane 0 carries data
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            awaddr_q     <= 8'h00;
            wdata_q      <= 8'h00;
            wstb_q       <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            align_q      <= `RST_ALIGN;
            fault_q      <= `RST_OPT;
            curlim_q     <= `RST_OPT;
            cldt_q       <= `RST_OPT;
            ipdreg_q     <= `RST_OPT;
            tach_q       <= `RST_OPT;
        end else begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (do_wr) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= whit ? `RESP_OKAY : `RESP_SLVERR;
                if (whit && wst) begin
                    case (widx)
                        {1'b0, `IDX_ALIGN}:  align_q  <= wd & `ALIGN_MASK;
                        {1'b0, `IDX_FAULT}:  fault_q  <= wd;
                        {1'b0, `IDX_CURLIM}: curlim_q <= wd & `CURLIM_MASK; // unused bit reads zero
                        {1'b0, `IDX_CLDT}:   cldt_q   <= wd;
                        {1'b0, `IDX_IPDREG}: ipdreg_q <= wd;
                        {1'b0, `IDX_TACH}:   tach_q   <= wd;
                        default:             align_q  <= align_q;
                    endcase
                end
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_q <= 1'b1;
                    awaddr_q  <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_q <= 1'b1;
                    wdata_q  <= s_axi_wdata[7:0];
                    wstb_q   <= s_axi_wstrb[0];
                end
            end
        end
    end

    wire [8:0] rsel = read_reg(reg_index(s_axi_araddr), align_q, fault_q, curlim_q, cldt_q, ipdreg_q, tach_q);

    // read channel; answer one cycle after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rsel[7:0]}; // upper bits zero
            s_axi_rresp  <= rsel[8] ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // align time table in centiseconds
    function [9:0] align_cs;
        input [2:0] c;
        begin
            case (c)
                3'd0:    align_cs = 10'd530;
                3'd1:    align_cs = 10'd270;
                3'd2:    align_cs = 10'd130;
                3'd3:    align_cs = 10'd67;
                3'd4:    align_cs = 10'd33;
                3'd5:    align_cs = 10'd16;
                3'd6:    align_cs = 10'd8;
                default: align_cs = 10'd4;
            endcase
        end
    endfunction

    // decode arithmetic at full width; largest products 3000 and 3200 mA need 12 bits
    wire [11:0] accel_ma = {8'h00, curlim_q[7:4]} * {2'b00, `ACCEL_STEP_MA};
    wire [11:0] lock_ma  = ({9'h000, curlim_q[3:1]} + 12'd1) * {2'b00, `LOCK_STEP_MA};
    wire [9:0]  dead_ns  = ({6'h00, cldt_q[3:0]} + 10'd1) * `DEAD_STEP_NS;
    wire [9:0]  dead_cyc = (dead_ns + `CLK_PERIOD_NS - 10'd1) / `CLK_PERIOD_NS;
    wire [11:0] ipd_ma   = ({8'h00, ipdreg_q[7:4]} + 12'd1) * {2'b00, `IPD_STEP_MA};
    wire [11:0] spd_lo   = {8'h00, loop_handover_speed[3:0]} * `SPD_STEP0_DHZ;
    wire [11:0] spd_hi   = ({8'h00, loop_handover_speed[3:0]} + 12'd1) * `SPD_STEP1_DHZ;

    // registered decode so the motor core sees glitch-free settings
    always @(posedge aclk) begin
        if (!aresetn) begin
            no_motor_fault_enable         <= 1'b0;
            torque_fault_enable           <= 1'b0;
            speed_fault_enable            <= 1'b0;
            lock_limit_fault_enable       <= 1'b0;
            inductive_surge_guard_enable  <= 1'b0;
            mechanical_surge_guard_enable <= 1'b0;
            surge_clamp_to_24v            <= 1'b0;
            release_high_impedance        <= 1'b0;
            accel_limit_active            <= 1'b0;
            accel_current_limit_ma        <= 12'h000;
            lock_current_limit_ma         <= 12'h000;
            closed_loop_stuck_enable      <= 1'b0;
            closed_loop_accel             <= 3'h0;
            dead_time_ns                  <= 10'h000;
            dead_time_cycles              <= 5'h00;
            position_detect_bypass        <= 1'b0;
            position_sense_threshold_ma   <= 12'h000;
            position_sense_rate_hz        <= 7'h00;
            open_loop_stuck_enable        <= 1'b0;
            regulator_3v3                 <= 1'b0;
            tach_in_open_loop             <= 1'b0;
            tach_first_open_loop_only     <= 1'b0;
            tach_pulses                   <= 2'h0;
            tach_cycles                   <= 2'h0;
            kt_high_x2                    <= 2'h0;
            kt_low_x4                     <= 2'h0;
            speed_input_pwm               <= 1'b0;
            closed_loop_allowed           <= 1'b0;
            handover_speed_dhz            <= 12'h000;
            alignment_time_cs             <= 10'h000;
            alignment_duration            <= 3'h0;
        end else begin
            no_motor_fault_enable         <= fault_q[7];
            torque_fault_enable           <= fault_q[6];
            speed_fault_enable            <= fault_q[5];
            lock_limit_fault_enable       <= fault_q[4];
            inductive_surge_guard_enable  <= fault_q[3];
            mechanical_surge_guard_enable <= fault_q[2];
            surge_clamp_to_24v            <= fault_q[1];
            release_high_impedance        <= fault_q[0];
            accel_limit_active            <= curlim_q[7:4] != 4'h0;
            accel_current_limit_ma        <= accel_ma;
            lock_current_limit_ma         <= lock_ma;
            closed_loop_stuck_enable      <= cldt_q[7];
            closed_loop_accel             <= cldt_q[6:4];
            dead_time_ns                  <= dead_ns;
            dead_time_cycles              <= dead_cyc[4:0]; // at most 13
            position_detect_bypass        <= ipdreg_q[7:4] == 4'h0;
            position_sense_threshold_ma   <= (ipdreg_q[7:4] == 4'h0) ? 12'h000 : ipd_ma;
            case (ipdreg_q[1:0])
                2'd0:    position_sense_rate_hz <= 7'd12;
                2'd1:    position_sense_rate_hz <= 7'd24;
                2'd2:    position_sense_rate_hz <= 7'd47;
                default: position_sense_rate_hz <= 7'd95;
            endcase
            open_loop_stuck_enable        <= ipdreg_q[3];
            regulator_3v3                 <= ipdreg_q[2];
            // reserved code 11 treated as closed loop only, the safest reading
            tach_in_open_loop             <= tach_q[7:6] == 2'b00 || tach_q[7:6] == 2'b10;
            tach_first_open_loop_only     <= tach_q[7:6] == 2'b10;
            case (tach_q[5:4])
                2'd0:    begin tach_pulses <= 2'd1; tach_cycles <= 2'd1; end
                2'd1:    begin tach_pulses <= 2'd2; tach_cycles <= 2'd3; end
                2'd2:    begin tach_pulses <= 2'd1; tach_cycles <= 2'd2; end
                default: begin tach_pulses <= 2'd1; tach_cycles <= 2'd3; end
            endcase
            kt_high_x2                    <= tach_q[2] ? 2'd0 : 2'd3; // 0 stands for 2Kt
            kt_low_x4                     <= tach_q[3] ? 2'd2 : 2'd3;
            speed_input_pwm               <= tach_q[1];
            closed_loop_allowed           <= !tach_q[0];
            handover_speed_dhz            <= loop_handover_speed[4] ? spd_hi : spd_lo;
            alignment_time_cs             <= align_cs(align_q[2:0]);
            alignment_duration            <= align_q[2:0];
        end
    end

endmodule // motor_option_register_bank
